// ### hw/rtc_bank_pkg.sv
package rtc_bank_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [6:0] index_t;

  // Bank selection; the fourth bank holds the interrupt registers
  typedef enum logic [1:0] {BANK_GP, BANK_CLOCK, BANK_POWER, BANK_IRQ} bank_e;

  // Field kinds used by the value range check
  typedef enum logic [2:0] {
    F_FREE, F_SIXTY, F_HOUR, F_WEEKDAY, F_MONTHDAY, F_MONTH, F_HUNDRED
  } field_e;

  // Shared indexes, present in every bank
  localparam index_t IDX_SECONDS = 7'h00;
  localparam index_t IDX_SEC_ALARM = 7'h01;
  localparam index_t IDX_MINUTES = 7'h02;
  localparam index_t IDX_MIN_ALARM = 7'h03;
  localparam index_t IDX_HOURS = 7'h04;
  localparam index_t IDX_HOUR_ALARM = 7'h05;
  localparam index_t IDX_WEEKDAY = 7'h06;
  localparam index_t IDX_MONTHDAY = 7'h07;
  localparam index_t IDX_MONTH = 7'h08;
  localparam index_t IDX_YEAR = 7'h09;
  localparam index_t IDX_CTL_FIRST = 7'h0A;
  localparam index_t IDX_CTL_SECOND = 7'h0B;
  localparam index_t IDX_CTL_THIRD = 7'h0C;
  localparam index_t IDX_CTL_FOURTH = 7'h0D;
  localparam index_t IDX_SHARED_RAM = 7'h0E;
  localparam index_t IDX_LOCKED_LOW = 7'h38;
  localparam index_t IDX_SHARED_LAST = 7'h3F;

  // Clock bank
  localparam index_t IDX_CLK_RSVD_FIRST = 7'h40;
  localparam index_t IDX_CLK_RSVD_LAST = 7'h47;
  localparam index_t IDX_CENTURY = 7'h48;
  localparam index_t IDX_UPPER_PTR = 7'h50;
  localparam index_t IDX_UPPER_DATA = 7'h53;

  // Power bank
  localparam index_t IDX_POWER_CTL1 = 7'h40;
  localparam index_t IDX_POWER_CTL2 = 7'h41;
  localparam index_t IDX_POWER_STATUS = 7'h42;
  localparam index_t IDX_WAKE_WEEKDAY = 7'h43;
  localparam index_t IDX_WAKE_MONTHDAY = 7'h44;
  localparam index_t IDX_WAKE_MONTH = 7'h45;
  localparam index_t IDX_WAKE_YEAR = 7'h46;
  localparam index_t IDX_RAM_LOCK = 7'h47;
  localparam index_t IDX_WAKE_CENTURY = 7'h48;

  // Interrupt bank
  localparam index_t IDX_IRQ_STATUS = 7'h40;
  localparam index_t IDX_IRQ_MASK = 7'h41;

  // Bit positions
  localparam int CTL_FIRST_RO_BIT = 7;
  localparam int CTL_SECOND_RO_BIT = 3;
  localparam int MODE_BIN_BIT = 2;
  localparam int MODE_24H_BIT = 1;
  localparam int PM_BIT = 7;
  localparam int LOCK_UPPER_PORT_BIT = 3;
  localparam int LOCK_UPPER_RD_BIT = 4;
  localparam int LOCK_UPPER_WR_BIT = 5;
  localparam int LOCK_RAM_WR_BIT = 6;
  localparam int LOCK_HIGH_SHARED_BIT = 7;
  localparam int STATUS_MATCH_BIT = 0;
  localparam int STATUS_RING_BIT = 7;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_POWER_BIT = 1;
  localparam int IRQ_MRESET_BIT = 2;

  // Masks and values
  localparam byte_t RST_ZERO = 8'h00;
  localparam byte_t RST_POWER_STATUS = 8'h41;
  localparam byte_t STATUS_RD_CLEAR = 8'h3F;
  localparam byte_t LOCK_WR_MASK = 8'hF8;
  localparam byte_t IRQ_MASK_BITS = 8'h07;
  localparam byte_t BLOCKED_READ = 8'hFF;
  localparam byte_t PTR_MASK = 8'h7F;
  localparam index_t UPPER_PROT_LAST = 7'h1F;

  // Register bus request, same clock domain
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    index_t addr;
    byte_t wrData;
  } bus_req_s;

  // Read-only flags from the time counting logic, same clock domain
  typedef struct packed {
    logic updateBusy;
    logic secondRoBit;
    byte_t thirdCtl;
    byte_t fourthCtl;
  } rtc_flags_s;

endpackage

// ### hw/rtc_bank_regs.sv
// Operation
// - Indexes 00h-3Fh reach the same clock registers and RAM in every bank.
// - Clock bank indexes 40h-47h ignore writes and read 00h.
// - Clock bank century register at 48h, read/write, resets to 00h.
// - Pointer at 50h selects one of 128 upper RAM bytes; bit 7 reserved.
// - Index 53h in clock bank reads/writes the upper byte pointed to.
// - General purpose bank 40h-7Fh is 64 bytes of read/write RAM.
// - Bit 7 at 0Ah, bit 3 at 0Bh, all of 0Ch/0Dh are read-only.
// - Weekday fields hold 01 to 07, Sunday is 1.
// - Power control registers 40h and 41h read/write, reset to 00h.
// - Power event status at 42h resets to 1000001 binary, bit 7 undefined.
// - RAM lock at 47h clears at reset and on master reset pin.
// - Power bank wake date at 43h-46h and 48h; 49h-7Fh reserved.
// - Wake fields compared continuously with current time and century.
// - Reading power event status clears its bits 5 to 0.
// - Set lock bits clear only by master reset pin, never by software; here arst_n reset also clears them.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

module rtc_bank_regs (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire rtc_bank_pkg::bank_e bankSel, // Selected register bank
  input wire rtc_bank_pkg::bus_req_s busReq, // Register bus request
  output rtc_bank_pkg::byte_t rdData, // Read data, cycle after strobe
  input wire rtc_bank_pkg::rtc_flags_s rtcFlags, // Read-only clock flags
  input wire logic [5:1] powerEvents, // Power event pulses
  input wire logic ringPin, // Ring pin level, asynchronous
  input wire logic masterResetPin, // Master reset pin, active high
  output logic irq // Interrupt, active high level
);
  import rtc_bank_pkg::*;

  typedef struct packed {
    logic [63:0][7:0] shared;
    logic [63:0][7:0] gpRam;
    logic [127:0][7:0] upperRam;
    byte_t century;
    byte_t upperPtr;
    byte_t powerCtl1;
    byte_t powerCtl2;
    byte_t powerStatus;
    byte_t wakeWeekday;
    byte_t wakeMonthday;
    byte_t wakeMonth;
    byte_t wakeYear;
    byte_t ramLock;
    byte_t wakeCentury;
    byte_t irqStatus;
    byte_t irqMask;
    byte_t rdData;
    logic irq;
    logic prevMatch;
    logic [1:0] resetPinSync;
    logic [1:0] ringSync;
  } state_s;

  state_s s;
  state_s next_s;

  // Range check of a time or date value in the active format
  function automatic logic fieldOk(input field_e kind, input byte_t v,
                                   input logic bin, input logic h24);
    byte_t h;
    byte_t n;
    logic digitsOk;
    logic inRange;
    h = v;
    if (kind == F_HOUR && !h24) begin
      h = {1'b0, v[6:0]}; // Afternoon flag rides on bit 7
    end
    digitsOk = bin || (h[3:0] <= 4'h9 && h[7:4] <= 4'h9);
    n = bin ? h : byte_t'({4'h0, h[7:4]} * 8'h0A + {4'h0, h[3:0]});
    case (kind)
      F_SIXTY: inRange = n <= 8'h3B;
      F_HOUR: inRange = h24 ? (n <= 8'h17) : (n >= 8'h01 && n <= 8'h0C);
      F_WEEKDAY: inRange = n >= 8'h01 && n <= 8'h07;
      F_MONTHDAY: inRange = n >= 8'h01 && n <= 8'h1F;
      F_MONTH: inRange = n >= 8'h01 && n <= 8'h0C;
      F_HUNDRED: inRange = n <= 8'h63;
      default: inRange = 1'b1;
    endcase
    return (kind == F_FREE) || (digitsOk && inRange);
  endfunction

  logic binMode;
  logic h24Mode;
  logic inShared;
  logic wakeMatch;
  logic matchRise;
  logic resetPinLevel;
  logic wrOk;
  logic upperRdBlock;
  logic upperWrBlock;
  field_e kind;
  byte_t rdVal;
  byte_t wrMasked;
  logic [5:0] slot;
  logic [6:0] uAddr;

  // Next state: bus decode, lock policy, events and interrupt
  always_comb begin
    next_s = s;
    slot = busReq.addr[5:0];
    uAddr = s.upperPtr[6:0];
    binMode = s.shared[IDX_CTL_SECOND[5:0]][MODE_BIN_BIT];
    h24Mode = s.shared[IDX_CTL_SECOND[5:0]][MODE_24H_BIT];
    inShared = busReq.addr <= IDX_SHARED_LAST;
    resetPinLevel = s.resetPinSync[1];
    rdVal = RST_ZERO;
    wrMasked = busReq.wrData;

    // Pin synchronisers
    next_s.resetPinSync = {s.resetPinSync[0], masterResetPin};
    next_s.ringSync = {s.ringSync[0], ringPin};

    // Wake moment comparison against the current time
    wakeMatch = s.shared[IDX_SECONDS[5:0]] == s.shared[IDX_SEC_ALARM[5:0]]
      && s.shared[IDX_MINUTES[5:0]] == s.shared[IDX_MIN_ALARM[5:0]]
      && s.shared[IDX_HOURS[5:0]] == s.shared[IDX_HOUR_ALARM[5:0]]
      && s.shared[IDX_WEEKDAY[5:0]] == s.wakeWeekday
      && s.shared[IDX_MONTHDAY[5:0]] == s.wakeMonthday
      && s.shared[IDX_MONTH[5:0]] == s.wakeMonth
      && s.shared[IDX_YEAR[5:0]] == s.wakeYear
      && s.century == s.wakeCentury;
    matchRise = wakeMatch && !s.prevMatch;
    next_s.prevMatch = wakeMatch;

    // Field kind of the addressed register for the range check
    kind = F_FREE;
    if (inShared) begin
      case (busReq.addr)
        IDX_SECONDS, IDX_SEC_ALARM, IDX_MINUTES, IDX_MIN_ALARM:
          kind = F_SIXTY;
        IDX_HOURS, IDX_HOUR_ALARM: kind = F_HOUR;
        IDX_WEEKDAY: kind = F_WEEKDAY;
        IDX_MONTHDAY: kind = F_MONTHDAY;
        IDX_MONTH: kind = F_MONTH;
        IDX_YEAR: kind = F_HUNDRED;
        default: kind = F_FREE;
      endcase
    end else if (bankSel == BANK_CLOCK && busReq.addr == IDX_CENTURY) begin
      kind = F_HUNDRED;
    end else if (bankSel == BANK_POWER) begin
      case (busReq.addr)
        IDX_WAKE_WEEKDAY: kind = F_WEEKDAY;
        IDX_WAKE_MONTHDAY: kind = F_MONTHDAY;
        IDX_WAKE_MONTH: kind = F_MONTH;
        IDX_WAKE_YEAR, IDX_WAKE_CENTURY: kind = F_HUNDRED;
        default: kind = F_FREE;
      endcase
    end
    wrOk = busReq.wrStrobe && fieldOk(kind, busReq.wrData, binMode, h24Mode);

    // Upper RAM protection from the lock bits
    upperRdBlock = s.ramLock[LOCK_UPPER_PORT_BIT]
      || (s.ramLock[LOCK_UPPER_RD_BIT] && uAddr <= UPPER_PROT_LAST);
    upperWrBlock = s.ramLock[LOCK_UPPER_PORT_BIT]
      || s.ramLock[LOCK_RAM_WR_BIT]
      || (s.ramLock[LOCK_UPPER_WR_BIT] && uAddr <= UPPER_PROT_LAST);

    // Power status: instantaneous ring level on bit 7
    next_s.powerStatus[STATUS_RING_BIT] = s.ringSync[1];

    if (inShared) begin
      // Shared area, identical in every bank
      if (busReq.addr >= IDX_LOCKED_LOW && s.ramLock[LOCK_HIGH_SHARED_BIT]) begin
        rdVal = BLOCKED_READ;
      end else begin
        case (busReq.addr)
          IDX_CTL_FIRST: begin
            rdVal = {rtcFlags.updateBusy, s.shared[slot][6:0]};
            wrMasked[CTL_FIRST_RO_BIT] = 1'b0;
          end
          IDX_CTL_SECOND: begin
            rdVal = s.shared[slot];
            rdVal[CTL_SECOND_RO_BIT] = rtcFlags.secondRoBit;
            wrMasked[CTL_SECOND_RO_BIT] = 1'b0;
          end
          IDX_CTL_THIRD: rdVal = rtcFlags.thirdCtl;
          IDX_CTL_FOURTH: rdVal = rtcFlags.fourthCtl;
          default: rdVal = s.shared[slot];
        endcase
        if (wrOk && busReq.addr != IDX_CTL_THIRD
            && busReq.addr != IDX_CTL_FOURTH) begin
          next_s.shared[slot] = wrMasked;
        end
      end
    end else begin
      case (bankSel)
        BANK_GP: begin
          rdVal = s.gpRam[slot];
          if (wrOk && !s.ramLock[LOCK_RAM_WR_BIT]) begin
            next_s.gpRam[slot] = busReq.wrData;
          end
        end
        BANK_CLOCK: begin
          case (busReq.addr)
            IDX_CENTURY: begin
              rdVal = s.century;
              if (wrOk) begin
                next_s.century = busReq.wrData;
              end
            end
            IDX_UPPER_PTR: begin
              rdVal = s.upperPtr & PTR_MASK;
              if (wrOk) begin
                next_s.upperPtr = busReq.wrData & PTR_MASK;
              end
            end
            IDX_UPPER_DATA: begin
              rdVal = upperRdBlock ? BLOCKED_READ : s.upperRam[uAddr];
              if (wrOk && !upperWrBlock) begin
                next_s.upperRam[uAddr] = busReq.wrData;
              end
            end
            default: rdVal = RST_ZERO; // Reserved, writes dropped
          endcase
        end
        BANK_POWER: begin
          case (busReq.addr)
            IDX_POWER_CTL1: begin
              rdVal = s.powerCtl1;
              if (wrOk) begin
                next_s.powerCtl1 = busReq.wrData;
              end
            end
            IDX_POWER_CTL2: begin
              rdVal = s.powerCtl2;
              if (wrOk) begin
                next_s.powerCtl2 = busReq.wrData;
              end
            end
            IDX_POWER_STATUS: begin
              rdVal = s.powerStatus;
              if (busReq.rdStrobe) begin
                next_s.powerStatus = s.powerStatus & ~STATUS_RD_CLEAR;
                next_s.powerStatus[STATUS_RING_BIT] = s.ringSync[1];
              end
            end
            IDX_WAKE_WEEKDAY: begin
              rdVal = s.wakeWeekday;
              if (wrOk) begin
                next_s.wakeWeekday = busReq.wrData;
              end
            end
            IDX_WAKE_MONTHDAY: begin
              rdVal = s.wakeMonthday;
              if (wrOk) begin
                next_s.wakeMonthday = busReq.wrData;
              end
            end
            IDX_WAKE_MONTH: begin
              rdVal = s.wakeMonth;
              if (wrOk) begin
                next_s.wakeMonth = busReq.wrData;
              end
            end
            IDX_WAKE_YEAR: begin
              rdVal = s.wakeYear;
              if (wrOk) begin
                next_s.wakeYear = busReq.wrData;
              end
            end
            IDX_RAM_LOCK: begin
              rdVal = s.ramLock;
              if (wrOk) begin
                // Bits only accumulate; a zero never clears
                next_s.ramLock = s.ramLock | (busReq.wrData & LOCK_WR_MASK);
              end
            end
            IDX_WAKE_CENTURY: begin
              rdVal = s.wakeCentury;
              if (wrOk) begin
                next_s.wakeCentury = busReq.wrData;
              end
            end
            default: rdVal = RST_ZERO; // Reserved 49h-7Fh
          endcase
        end
        default: begin
          case (busReq.addr)
            IDX_IRQ_STATUS: begin
              rdVal = s.irqStatus;
              if (busReq.wrStrobe) begin
                next_s.irqStatus = s.irqStatus & ~busReq.wrData;
              end
            end
            IDX_IRQ_MASK: begin
              rdVal = s.irqMask;
              if (busReq.wrStrobe) begin
                next_s.irqMask = busReq.wrData & IRQ_MASK_BITS;
              end
            end
            default: rdVal = RST_ZERO;
          endcase
        end
      endcase
    end

    // Event sets come after clears so a coincident event wins
    next_s.powerStatus[5:1] = next_s.powerStatus[5:1] | powerEvents;
    if (matchRise) begin
      next_s.powerStatus[STATUS_MATCH_BIT] = 1'b1;
      next_s.irqStatus[IRQ_WAKE_BIT] = 1'b1;
    end
    if (|powerEvents) begin
      next_s.irqStatus[IRQ_POWER_BIT] = 1'b1;
    end
    if (resetPinLevel) begin
      next_s.ramLock = RST_ZERO; // Master reset pin overrides writes
      next_s.irqStatus[IRQ_MRESET_BIT] = 1'b1;
    end

    // Registered outputs
    next_s.rdData = busReq.rdStrobe ? rdVal : RST_ZERO;
    next_s.irq = |(next_s.irqStatus & next_s.irqMask);
  end

  // State register; power-up values on reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0; // Control, century and lock clear to 00h
      s.powerStatus <= RST_POWER_STATUS;
      s.prevMatch <= 1'b1; // Zeroed time already matches at power-up
    end else begin
      s <= next_s;
    end
  end

  assign rdData = s.rdData;
  assign irq = s.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Read-only third control register reflects its source
  a_ro_third_ctl: assert property (
    busReq.rdStrobe && busReq.addr == IDX_CTL_THIRD
    |=> rdData == $past(rtcFlags.thirdCtl))
    else $error("third control register read mismatch");

  // Clock bank reserved reads give zero
  a_clk_rsvd_zero: assert property (
    busReq.rdStrobe && bankSel == BANK_CLOCK
    && busReq.addr >= IDX_CLK_RSVD_FIRST && busReq.addr <= IDX_CLK_RSVD_LAST
    |=> rdData == RST_ZERO)
    else $error("clock bank reserved read not zero");

  // Century stores a legal binary write
  a_century_store: assert property (
    busReq.wrStrobe && bankSel == BANK_CLOCK && busReq.addr == IDX_CENTURY
    && binMode && busReq.wrData <= 8'h63
    |=> s.century == $past(busReq.wrData))
    else $error("century write lost");

  // Pointer keeps seven address bits
  a_ptr_low_bits: assert property (
    busReq.wrStrobe && bankSel == BANK_CLOCK && busReq.addr == IDX_UPPER_PTR
    |=> s.upperPtr == {1'b0, $past(busReq.wrData[6:0])})
    else $error("upper pointer write wrong");

  // High shared area lock bit 7 survives anything except the master reset pin
  a_lock_sticky: assert property (
    s.ramLock[LOCK_HIGH_SHARED_BIT] && !s.resetPinSync[1]
    |=> s.ramLock[LOCK_HIGH_SHARED_BIT])
    else $error("lock bit cleared without master reset");

  // Master reset pin held three cycles clears the lock in the cycle after
  a_lock_mr_clear: assert property (
    masterResetPin [*3] |=> s.ramLock == RST_ZERO)
    else $error("lock not cleared by master reset");

  // Status read clears event bits when no new event arrives
  a_status_rd_clear: assert property (
    busReq.rdStrobe && bankSel == BANK_POWER
    && busReq.addr == IDX_POWER_STATUS && powerEvents == 5'h00
    |=> s.powerStatus[5:1] == 5'h00)
    else $error("status not cleared by read");

  // General purpose bank write lands unless locked
  a_gp_bank_write: assert property (
    busReq.wrStrobe && bankSel == BANK_GP && busReq.addr[6]
    && !s.ramLock[LOCK_RAM_WR_BIT]
    |=> s.gpRam[$past(slot)] == $past(busReq.wrData))
    else $error("general purpose RAM write lost");

  // Weekday zero is refused
  a_weekday_range: assert property (
    busReq.wrStrobe && busReq.addr == IDX_WEEKDAY && busReq.wrData == 8'h00
    |=> $stable(s.shared[IDX_WEEKDAY[5:0]]))
    else $error("illegal weekday accepted");

  // Wake match sets the status bit and a pending interrupt
  a_wake_event: assert property (
    matchRise |=> s.powerStatus[STATUS_MATCH_BIT] && s.irqStatus[IRQ_WAKE_BIT])
    else $error("wake match not recorded");

  // Unmasked power event raises the interrupt one cycle later
  a_irq_level: assert property (
    |powerEvents && s.irqMask[IRQ_POWER_BIT] && !busReq.wrStrobe |=> irq)
    else $error("interrupt level mismatch");

endmodule // rtc_bank_regs

// ### sim/tb.sv
`timescale 1ns/1ps

module tb;
  import rtc_bank_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  bank_e bankSel = BANK_GP;
  bus_req_s busReq = '0;
  byte_t rdData;
  rtc_flags_s rtcFlags = '0;
  logic [5:1] powerEvents = '0;
  logic ringPin = 1'b1;
  logic masterResetPin = 1'b0;
  logic irq;
  int fails = 0;
  int testsRun = 0;

  rtc_bank_regs rtc_bank_regs_inst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .bankSel(bankSel),
    .busReq(busReq),
    .rdData(rdData),
    .rtcFlags(rtcFlags),
    .powerEvents(powerEvents),
    .ringPin(ringPin),
    .masterResetPin(masterResetPin),
    .irq(irq)
  );

  // Free running system clock
  always #12.5 clk_sys = ~clk_sys;

  // Compare one value with its expectation
  task automatic chk(input byte_t seen, input byte_t exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input bank_e b, input index_t a, input byte_t d);
    @(posedge clk_sys);
    bankSel <= b;
    busReq <= '{wrStrobe: 1'b1, rdStrobe: 1'b0, addr: a, wrData: d};
    @(posedge clk_sys);
    busReq.wrStrobe <= 1'b0;
  endtask

  // One-cycle read strobe, data judged in the following cycle
  task automatic rdc(input bank_e b, input index_t a, input byte_t exp,
                     input byte_t m = 8'hFF);
    @(posedge clk_sys);
    bankSel <= b;
    busReq <= '{wrStrobe: 1'b0, rdStrobe: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk_sys);
    busReq.rdStrobe <= 1'b0;
    #1;
    chk(rdData & m, exp);
  endtask

  // Single-cycle power event pulse on one bit
  task automatic pulse(input logic [5:1] ev);
    @(posedge clk_sys);
    powerEvents <= ev;
    @(posedge clk_sys);
    powerEvents <= '0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Power-up values of the banked registers
  task automatic t_reset();
    rdc(BANK_POWER, IDX_POWER_CTL1, 8'h00);
    rdc(BANK_POWER, IDX_POWER_CTL2, 8'h00);
    rdc(BANK_POWER, IDX_POWER_STATUS, 8'h41, 8'h7F);
    rdc(BANK_POWER, IDX_POWER_STATUS, 8'hC0);
    rdc(BANK_POWER, IDX_RAM_LOCK, 8'h00);
    rdc(BANK_CLOCK, IDX_CENTURY, 8'h00);
    $display("test reset done");
  endtask

  // Shared low indexes, reserved holes and general purpose bank
  task automatic t_map();
    wr(BANK_GP, 7'h0E, 8'hA5);
    wr(BANK_POWER, IDX_SECONDS, 8'h59);
    rdc(BANK_CLOCK, 7'h0E, 8'hA5);
    rdc(BANK_POWER, 7'h0E, 8'hA5);
    rdc(BANK_GP, IDX_SECONDS, 8'h59);
    for (int i = 8'h40; i <= 8'h47; i++) begin
      wr(BANK_CLOCK, index_t'(i), 8'h5A);
      rdc(BANK_CLOCK, index_t'(i), 8'h00);
    end
    wr(BANK_GP, 7'h40, 8'h3C);
    wr(BANK_GP, 7'h7F, 8'hC3);
    rdc(BANK_GP, 7'h40, 8'h3C);
    rdc(BANK_GP, 7'h7F, 8'hC3);
    wr(BANK_CLOCK, IDX_CENTURY, 8'h99);
    wr(BANK_CLOCK, IDX_CENTURY, 8'h9A);
    rdc(BANK_CLOCK, IDX_CENTURY, 8'h99);
    $display("test map done");
  endtask

  // Indirect upper RAM through pointer and data port
  task automatic t_upper();
    wr(BANK_CLOCK, IDX_UPPER_PTR, 8'h85);
    wr(BANK_CLOCK, IDX_UPPER_DATA, 8'h11);
    wr(BANK_CLOCK, IDX_UPPER_PTR, 8'h06);
    wr(BANK_CLOCK, IDX_UPPER_DATA, 8'h22);
    rdc(BANK_CLOCK, IDX_UPPER_PTR, 8'h06, 8'h7F);
    wr(BANK_CLOCK, IDX_UPPER_PTR, 8'h05);
    rdc(BANK_CLOCK, IDX_UPPER_DATA, 8'h11);
    wr(BANK_CLOCK, IDX_UPPER_PTR, 8'h06);
    rdc(BANK_CLOCK, IDX_UPPER_DATA, 8'h22);
    $display("test upper done");
  endtask

  // Read-only control bits follow the clock flags
  task automatic t_ro();
    @(posedge clk_sys);
    rtcFlags <= '{updateBusy: 1'b0, secondRoBit: 1'b0,
                  thirdCtl: 8'hA5, fourthCtl: 8'h5A};
    wr(BANK_CLOCK, IDX_CTL_FIRST, 8'hFF);
    rdc(BANK_CLOCK, IDX_CTL_FIRST, 8'h7F);
    wr(BANK_CLOCK, IDX_CTL_SECOND, 8'hF8);
    rdc(BANK_CLOCK, IDX_CTL_SECOND, 8'hF0);
    wr(BANK_CLOCK, IDX_CTL_THIRD, 8'h00);
    wr(BANK_CLOCK, IDX_CTL_FOURTH, 8'h00);
    rdc(BANK_CLOCK, IDX_CTL_THIRD, 8'hA5);
    rdc(BANK_CLOCK, IDX_CTL_FOURTH, 8'h5A);
    @(posedge clk_sys);
    rtcFlags <= '{updateBusy: 1'b1, secondRoBit: 1'b1,
                  thirdCtl: 8'hA5, fourthCtl: 8'h5A};
    rdc(BANK_CLOCK, IDX_CTL_FIRST, 8'hFF);
    rdc(BANK_CLOCK, IDX_CTL_SECOND, 8'hF8);
    wr(BANK_CLOCK, IDX_CTL_SECOND, 8'h00);
    $display("test readonly done");
  endtask

  // Field ranges in twelve-hour decimal-coded mode
  task automatic t_range();
    wr(BANK_CLOCK, IDX_WEEKDAY, 8'h07);
    wr(BANK_CLOCK, IDX_WEEKDAY, 8'h08);
    rdc(BANK_CLOCK, IDX_WEEKDAY, 8'h07);
    wr(BANK_CLOCK, IDX_WEEKDAY, 8'h00);
    rdc(BANK_CLOCK, IDX_WEEKDAY, 8'h07);
    wr(BANK_CLOCK, IDX_HOURS, 8'h92);
    wr(BANK_CLOCK, IDX_HOURS, 8'h13);
    rdc(BANK_CLOCK, IDX_HOURS, 8'h92);
    wr(BANK_CLOCK, IDX_MONTH, 8'h12);
    wr(BANK_CLOCK, IDX_MONTH, 8'h13);
    rdc(BANK_CLOCK, IDX_MONTH, 8'h12);
    wr(BANK_CLOCK, IDX_MINUTES, 8'h60);
    rdc(BANK_CLOCK, IDX_MINUTES, 8'h00);
    $display("test range done");
  endtask

  // Power bank control and wake-up date fields
  task automatic t_power();
    wr(BANK_POWER, IDX_POWER_CTL2, 8'h33);
    rdc(BANK_POWER, IDX_POWER_CTL2, 8'h33);
    wr(BANK_POWER, IDX_WAKE_WEEKDAY, 8'h07);
    wr(BANK_POWER, IDX_WAKE_MONTHDAY, 8'h31);
    wr(BANK_POWER, IDX_WAKE_YEAR, 8'h99);
    wr(BANK_POWER, IDX_WAKE_CENTURY, 8'h20);
    wr(BANK_POWER, IDX_WAKE_MONTH, 8'h13);
    wr(BANK_POWER, 7'h49, 8'h77);
    rdc(BANK_POWER, IDX_WAKE_WEEKDAY, 8'h07);
    rdc(BANK_POWER, IDX_WAKE_MONTHDAY, 8'h31);
    rdc(BANK_POWER, IDX_WAKE_YEAR, 8'h99);
    rdc(BANK_POWER, IDX_WAKE_CENTURY, 8'h20);
    rdc(BANK_POWER, IDX_WAKE_MONTH, 8'h00);
    rdc(BANK_POWER, 7'h49, 8'h00);
    $display("test power done");
  endtask

  // Wake-up moment reached once every compared field agrees
  task automatic t_wake();
    wr(BANK_CLOCK, IDX_SEC_ALARM, 8'h59);
    wr(BANK_CLOCK, IDX_HOUR_ALARM, 8'h92);
    wr(BANK_CLOCK, IDX_MONTHDAY, 8'h31);
    wr(BANK_POWER, IDX_WAKE_MONTH, 8'h12);
    wr(BANK_CLOCK, IDX_YEAR, 8'h99);
    wr(BANK_CLOCK, IDX_CENTURY, 8'h20);
    rdc(BANK_POWER, IDX_POWER_STATUS, 8'h01, 8'h01);
    rdc(BANK_IRQ, IDX_IRQ_STATUS, 8'h01, 8'h01);
    rdc(BANK_POWER, IDX_POWER_STATUS, 8'h00, 8'h01);
    $display("test wake done");
  endtask

  // Field ranges in twenty-four-hour binary mode
  task automatic t_binary();
    wr(BANK_CLOCK, IDX_CTL_SECOND, 8'h06);
    wr(BANK_CLOCK, IDX_HOURS, 8'h17);
    wr(BANK_CLOCK, IDX_HOURS, 8'h18);
    rdc(BANK_CLOCK, IDX_HOURS, 8'h17);
    wr(BANK_CLOCK, IDX_CENTURY, 8'h63);
    wr(BANK_CLOCK, IDX_CENTURY, 8'h64);
    rdc(BANK_CLOCK, IDX_CENTURY, 8'h63);
    wr(BANK_CLOCK, IDX_CTL_SECOND, 8'h00);
    $display("test binary done");
  endtask

  // Sticky event status, mask and level interrupt
  task automatic t_irq();
    wr(BANK_IRQ, IDX_IRQ_MASK, 8'h02);
    pulse(5'h01);
    chk({7'h00, irq}, 8'h01);
    rdc(BANK_POWER, IDX_POWER_STATUS, 8'h02, 8'h02);
    rdc(BANK_POWER, IDX_POWER_STATUS, 8'h00, 8'h02);
    wr(BANK_IRQ, IDX_IRQ_STATUS, 8'h07);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr(BANK_IRQ, IDX_IRQ_MASK, 8'h00);
    pulse(5'h01);
    chk({7'h00, irq}, 8'h00);
    wr(BANK_IRQ, IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(BANK_IRQ, IDX_IRQ_STATUS, 8'h07);
    $display("test irq done");
  endtask

  // Lock register set by software, cleared only by the pin
  task automatic t_lock();
    wr(BANK_GP, 7'h38, 8'h44);
    wr(BANK_POWER, IDX_RAM_LOCK, 8'hFF);
    rdc(BANK_POWER, IDX_RAM_LOCK, 8'hF8);
    wr(BANK_POWER, IDX_RAM_LOCK, 8'h00);
    rdc(BANK_POWER, IDX_RAM_LOCK, 8'hF8);
    rdc(BANK_CLOCK, 7'h38, 8'hFF);
    @(posedge clk_sys);
    masterResetPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    masterResetPin <= 1'b0;
    rdc(BANK_POWER, IDX_RAM_LOCK, 8'h00);
    rdc(BANK_CLOCK, 7'h38, 8'h44);
    $display("test lock done");
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_map();
    t_upper();
    t_ro();
    t_range();
    t_power();
    t_wake();
    t_binary();
    t_irq();
    t_lock();
    close_out();
  end
endmodule // tb
